// file: hw/dri_map.svh
// Purpose: offsets, presets and timing counts of the digitizer readout logic
// Assumes: ref_clk runs at 250 MHz
// Notes:   definitions only
`ifndef DRI_MAP_SVH
`define DRI_MAP_SVH
`define DRI_CLK_PS        4000
`define DRI_PAIR_NS       25
`define DRI_WORD_NS       400
`define DRI_UNLOAD_NS     50
`define DRI_FREE_NS       200
`define DRI_UNLOAD_CYC    ((`DRI_UNLOAD_NS * 1000) / `DRI_CLK_PS)
`define DRI_FREE_CYC      ((`DRI_FREE_NS * 1000) / `DRI_CLK_PS)
`define DRI_SR_BITS       16
`define DRI_PRESET        4'hF
`define DRI_SEL_WINDOW    256
`define DRI_FIFO_DEPTH    16
`endif

// file: hw/dri_pkg.sv
// Purpose: shared types of the digitizer readout logic
// Assumes: nothing
// Notes:   constants live in dri_map.svh
package dri_pkg;
  typedef struct packed {
    logic [7:0] clk;
    logic [7:0] wen;
    logic [7:0] ctrl;
  } dri_board_t;
  typedef struct packed {
    logic [3:0]  chip;
    logic [31:0] data;
  } dri_word_t;
  typedef enum logic [1:0] {
    DRI_SEL_COUNT = 2'b01,
    DRI_SEL_DONE  = 2'b10
  } dri_sel_state_t;
endpackage : dri_pkg

// file: hw/dri_interface_logic.sv
// Purpose: gather serial digitizer data, time-align it, page it and queue it in channel order, or in tower order when tower_order is set
// Assumes: one ref_clk; board clocks, data and candidate clocks arrive asynchronously
// Notes:   board and candidate clocks are sampled, their rising edges act as enables
`timescale 1ns/10ps
`default_nettype none
`include "dri_map.svh"
module dri_interface_logic #(
  parameter int NCHIP      = 16,
  parameter int FIFO_DEPTH = `DRI_FIFO_DEPTH,
  parameter int SEL_WINDOW = `DRI_SEL_WINDOW
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire dri_pkg::dri_board_t board_in,
  input  wire logic [31:0]         chip_data,
  input  wire logic [2:0]          cand_clk,
  input  wire logic                tower_order,
  input  wire logic                out_ready,
  output logic                     out_valid,
  output dri_pkg::dri_word_t       out_word,
  output logic [2:0]               master_sel,
  output logic                     sel_done
);
  localparam int NRAW = 59;
  localparam int FAW  = $clog2(FIFO_DEPTH);
  localparam logic [3:0] UNLOAD_LAST = 4'(`DRI_UNLOAD_CYC - 1);
  function automatic logic close_cnt(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= 16'h0001;
  endfunction : close_cnt
  // tower order walks even chips first, then odd ones
  function automatic logic [3:0] order_map(input logic [3:0] i, input logic tw);
    return tw ? {i[2:0], i[3]} : i;
  endfunction : order_map
  // three-stage sampling; a change counts once stages two and three agree
  logic [NRAW-1:0] s1_reg, s2_reg, s3_reg, stab_reg, stab_next, rise;
  always_comb begin
    stab_next = stab_reg;
    for (int i = 0; i < NRAW; i++) begin
      if (s2_reg[i] == s3_reg[i]) stab_next[i] = s3_reg[i];
    end
    rise = stab_next & ~stab_reg;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      stab_reg <= '0;
    end else begin
      s1_reg   <= {cand_clk, chip_data, board_in.ctrl, board_in.wen, board_in.clk};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      stab_reg <= stab_next;
    end
  end
  wire logic [7:0]  b_edge = rise[7:0];
  wire logic [7:0]  b_wen  = stab_next[15:8];
  wire logic [7:0]  b_ctrl = stab_next[23:16];
  wire logic [31:0] d_in   = stab_next[55:24];
  wire logic [2:0]  c_edge = rise[58:56];
  // serial-to-parallel stages and pipe registers
  logic [15:0] sr0_reg [NCHIP], sr0_next [NCHIP];
  logic [15:0] sr1_reg [NCHIP], sr1_next [NCHIP];
  logic [3:0]  cnt_reg [NCHIP], cnt_next [NCHIP];
  logic [31:0] pw_reg  [NCHIP], pw_next  [NCHIP];
  logic [NCHIP-1:0] pf_reg, pf_next, done;
  logic [3:0]  ucnt_reg, ucnt_next;
  logic [2:0]  ubrd_reg, ubrd_next;
  logic        utick;
  always_comb begin
    ucnt_next = (ucnt_reg == UNLOAD_LAST) ? 4'h0 : ucnt_reg + 4'h1;
    utick     = (ucnt_reg == UNLOAD_LAST);
    ubrd_next = utick ? ubrd_reg + 3'h1 : ubrd_reg;
    pf_next   = pf_reg;
    if (utick) begin
      pf_next[{ubrd_reg, 1'b0}] = 1'b0;
      pf_next[{ubrd_reg, 1'b1}] = 1'b0;
    end
    for (int c = 0; c < NCHIP; c++) begin
      sr0_next[c] = sr0_reg[c];
      sr1_next[c] = sr1_reg[c];
      cnt_next[c] = cnt_reg[c];
      pw_next[c]  = pw_reg[c];
      done[c]     = 1'b0;
      if (b_edge[c/2]) begin
        if (b_ctrl[c/2]) begin
          cnt_next[c] = `DRI_PRESET;
        end else if (b_wen[c/2]) begin
          sr0_next[c] = {sr0_reg[c][14:0], d_in[2*c]};
          sr1_next[c] = {sr1_reg[c][14:0], d_in[2*c+1]};
          cnt_next[c] = cnt_reg[c] - 4'h1;
          if (cnt_reg[c] == 4'h0) begin
            done[c]     = 1'b1;
            cnt_next[c] = `DRI_PRESET;
            pw_next[c]  = {sr1_next[c], sr0_next[c]};
            pf_next[c]  = 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < NCHIP; c++) begin
        sr0_reg[c] <= '0;
        sr1_reg[c] <= '0;
        cnt_reg[c] <= `DRI_PRESET;
        pw_reg[c]  <= '0;
      end
      pf_reg   <= '0;
      ucnt_reg <= '0;
      ubrd_reg <= '0;
    end else begin
      sr0_reg  <= sr0_next;
      sr1_reg  <= sr1_next;
      cnt_reg  <= cnt_next;
      pw_reg   <= pw_next;
      pf_reg   <= pf_next;
      ucnt_reg <= ucnt_next;
      ubrd_reg <= ubrd_next;
    end
  end
  // two-page input buffer, then ordered drain into the output FIFO
  logic [31:0] page_mem [2*NCHIP];
  logic [NCHIP-1:0] fmask_reg, fmask_next;
  logic        fpage_reg, fpage_next, drn_reg, drn_next;
  logic [3:0]  didx_reg, didx_next;
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [3:0]  fchip    [FIFO_DEPTH];
  logic [FAW:0] wp_reg, wp_next, rp_reg, rp_next;
  logic        full, empty, push, pop;
  logic [3:0]  dch;
  always_comb begin
    full       = (wp_reg[FAW] != rp_reg[FAW]) && (wp_reg[FAW-1:0] == rp_reg[FAW-1:0]);
    empty      = (wp_reg == rp_reg);
    dch        = order_map(didx_reg, tower_order);
    push       = drn_reg && !full;
    pop        = !empty && out_ready;
    wp_next    = push ? wp_reg + 1'b1 : wp_reg;
    rp_next    = pop ? rp_reg + 1'b1 : rp_reg;
    didx_next  = push ? didx_reg + 4'h1 : didx_reg;
    drn_next   = drn_reg && !(push && didx_reg == 4'hF);
    fmask_next = fmask_reg;
    fpage_next = fpage_reg;
    if (&fmask_reg && !drn_reg) begin
      fpage_next = !fpage_reg;
      fmask_next = '0;
      drn_next   = 1'b1;
      didx_next  = 4'h0;
    end
    // a word unloaded in the swap cycle belongs to the new fill page, so set wins over clear
    if (utick) begin
      fmask_next[{ubrd_reg, 1'b0}] = fmask_next[{ubrd_reg, 1'b0}] | pf_reg[{ubrd_reg, 1'b0}];
      fmask_next[{ubrd_reg, 1'b1}] = fmask_next[{ubrd_reg, 1'b1}] | pf_reg[{ubrd_reg, 1'b1}];
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmask_reg <= '0;
      fpage_reg <= 1'b0;
      drn_reg   <= 1'b0;
      didx_reg  <= '0;
      wp_reg    <= '0;
      rp_reg    <= '0;
    end else begin
      fmask_reg <= fmask_next;
      fpage_reg <= fpage_next;
      drn_reg   <= drn_next;
      didx_reg  <= didx_next;
      wp_reg    <= wp_next;
      rp_reg    <= rp_next;
    end
  end
  // storage only, no reset needed; valid flags guard every read
  always_ff @(posedge ref_clk) begin
    if (utick) begin
      for (int k = 0; k < 2; k++) begin
        if (pf_reg[{ubrd_reg, k[0]}]) begin
          page_mem[{fpage_next, ubrd_reg, k[0]}] <= pw_reg[{ubrd_reg, k[0]}];
        end
      end
    end
    if (push) begin
      fifo_mem[wp_reg[FAW-1:0]] <= page_mem[{!fpage_reg, dch}];
      fchip[wp_reg[FAW-1:0]]    <= dch;
    end
  end
  always_comb begin
    out_valid     = !empty;
    out_word.data = fifo_mem[rp_reg[FAW-1:0]];
    out_word.chip = fchip[rp_reg[FAW-1:0]];
  end
  // master clock choice over a counting window after reset
  dri_pkg::dri_sel_state_t st_reg, st_next;
  logic [15:0] cc_reg [3], cc_next [3];
  logic [15:0] win_reg, win_next;
  logic [2:0]  msel_reg, msel_next;
  always_comb begin
    st_next   = st_reg;
    win_next  = win_reg;
    msel_next = msel_reg;
    cc_next   = cc_reg;
    unique case (st_reg)
      dri_pkg::DRI_SEL_COUNT: begin
        for (int k = 0; k < 3; k++) begin
          if (c_edge[k]) cc_next[k] = cc_reg[k] + 16'h0001;
        end
        win_next = win_reg + 16'h0001;
        if (win_reg == 16'(SEL_WINDOW - 1)) begin
          st_next = dri_pkg::DRI_SEL_DONE;
          if (close_cnt(cc_reg[0], cc_reg[1]) || close_cnt(cc_reg[0], cc_reg[2])) begin
            msel_next = 3'h1;
          end else if (close_cnt(cc_reg[1], cc_reg[2])) begin
            msel_next = 3'h2;
          end else begin
            msel_next = 3'h1;
          end
        end
      end
      dri_pkg::DRI_SEL_DONE: begin
        st_next = dri_pkg::DRI_SEL_DONE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg   <= dri_pkg::DRI_SEL_COUNT;
      win_reg  <= '0;
      msel_reg <= 3'h1;
      for (int k = 0; k < 3; k++) cc_reg[k] <= '0;
    end else begin
      st_reg   <= st_next;
      win_reg  <= win_next;
      msel_reg <= msel_next;
      cc_reg   <= cc_next;
    end
  end
  assign master_sel = msel_reg;
  assign sel_done   = (st_reg == dri_pkg::DRI_SEL_DONE);
  property p_onehot_sel;
    @(posedge ref_clk) disable iff (!reset_n) $onehot(master_sel);
  endproperty
  a_onehot_sel: assert property (p_onehot_sel) else $error("master select not one-hot");
  property p_sel_stable;
    @(posedge ref_clk) disable iff (!reset_n) sel_done |=> sel_done && $stable(master_sel);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("master select moved");
  property p_sel_default;
    @(posedge ref_clk) disable iff (!reset_n) !sel_done |-> master_sel == 3'h1;
  endproperty
  a_sel_default: assert property (p_sel_default) else $error("no default candidate");
  property p_fifo_full;
    @(posedge ref_clk) disable iff (!reset_n) full && !pop |=> $stable(wp_reg);
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("write taken while full");
  property p_fifo_empty;
    @(posedge ref_clk) disable iff (!reset_n) empty |-> !out_valid ##1 $stable(rp_reg);
  endproperty
  a_fifo_empty: assert property (p_fifo_empty) else $error("read taken while empty");
  property p_unload_period;
    @(posedge ref_clk) disable iff (!reset_n) utick |=> !utick [*8] ##1 !utick [*3] ##1 utick;
  endproperty
  a_unload_period: assert property (p_unload_period) else $error("unload period wrong");
  property p_pipe_free;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(pf_reg[0]) |-> ##[0:100] !pf_reg[0] || done[0];
  endproperty
  a_pipe_free: assert property (p_pipe_free) else $error("pipe register held too long");
  property p_word_load;
    @(posedge ref_clk) disable iff (!reset_n) done[0] |=> pf_reg[0] && pw_reg[0] == $past(pw_next[0]);
  endproperty
  a_word_load: assert property (p_word_load) else $error("finished word not loaded");
  property p_drain_len;
    @(posedge ref_clk) disable iff (!reset_n) $rose(drn_reg) |-> ##[16:1000] !drn_reg;
  endproperty
  a_drain_len: assert property (p_drain_len) else $error("page drain never ends");
endmodule : dri_interface_logic
`default_nettype wire

// file: test/dri_board_model.sv
// Purpose: eight digitizer boards, two chips each, sending bit pairs on their own clocks
// Assumes: frame() is called by the bench with words[] already loaded
// Notes:   the clock stands low between frames; idle data lines show the inverse of the last bit
`timescale 1ns/10ps
`default_nettype none
module dri_board_model (
  output var dri_pkg::dri_board_t board,
  output var logic [31:0]         data
);
  logic [31:0] words [16];

  initial begin
    board = '0;
    data  = '0;
  end

  // one bit pair per board clock period of 160 ns, data set well before the rise
  task automatic send_edge(input int b, input logic w, input logic c, input logic [3:0] d);
    board.wen[b]  = w;
    board.ctrl[b] = c;
    data[4*b+:4]  = d;
    #40 board.clk[b] = 1'b1;
    #80 board.clk[b] = 1'b0;
    #40;
  endtask : send_edge

  // both chips of a board share clock, enable and control, each has its own two lines
  task automatic board_frame(input int b);
    int k;
    #(b * 19 + 3);
    send_edge(b, 1'b0, 1'b1, ~data[4*b+:4]);
    for (k = 0; k < 16; k++) begin
      // an edge without enable carries junk that must not be shifted in
      if (k == 8) send_edge(b, 1'b0, 1'b0, ~data[4*b+:4]);
      send_edge(b, 1'b1, 1'b0, {words[2*b+1][31-k], words[2*b+1][15-k],
                                words[2*b][31-k], words[2*b][15-k]});
    end
    board.wen[b] = 1'b0;
    data[4*b+:4] = ~data[4*b+:4];
  endtask : board_frame

  task automatic frame();
    for (int b = 0; b < 8; b++) begin
      automatic int bb = b;
      fork
        board_frame(bb);
      join_none
    end
    wait fork;
  endtask : frame
endmodule : dri_board_model
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench of the digitizer readout logic
// Assumes: a short selection window of 64 cycles
// Notes:   expected words and selections are queued by the driver, popped by monitors
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                ref_clk;
  logic                reset_n;
  logic                tower_order;
  logic                out_ready;
  logic                out_valid;
  logic                sel_done;
  logic                done_d;
  logic [2:0]          cand_clk;
  logic [2:0]          tog;
  logic [2:0]          master_sel;
  logic [31:0]         chip_data;
  logic [31:0]         lfsr;
  dri_pkg::dri_board_t board;
  dri_pkg::dri_word_t  out_word;
  dri_pkg::dri_word_t  word_q[$];
  logic [2:0]          sel_q[$];
  int                  bad_count;
  int                  cmp_count;
  int                  half[3];
  int                  ccnt[3];

  dri_interface_logic #(.SEL_WINDOW(64)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .board_in(board), .chip_data(chip_data),
    .cand_clk(cand_clk), .tower_order(tower_order), .out_ready(out_ready),
    .out_valid(out_valid), .out_word(out_word), .master_sel(master_sel), .sel_done(sel_done));

  dri_board_model P (.board(board), .data(chip_data));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic fail(input string msg);
    bad_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_word(input dri_pkg::dri_word_t got, input dri_pkg::dri_word_t exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask : chk_word

  task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("bits %b, expected %b", got, exp));
  endtask : chk_bits

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // candidate clocks toggle every half[i] cycles, 0 keeps one dead
  always @(posedge ref_clk) begin
    lfsr <= lfsr_next(lfsr);
    out_ready <= lfsr[3] | lfsr[9];
    for (int i = 0; i < 3; i++) begin
      tog[i] = 1'b0;
      if (half[i] != 0) begin
        ccnt[i] = ccnt[i] + 1;
        if (ccnt[i] >= half[i]) begin
          ccnt[i] = 0;
          tog[i] = 1'b1;
        end
      end
    end
    cand_clk <= cand_clk ^ tog;
  end

  always @(posedge ref_clk) begin
    if (reset_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (word_q.size() == 0) fail("word with none expected");
      else chk_word(out_word, word_q.pop_front());
    end
    if (sel_done === 1'b1 && done_d !== 1'b1) begin
      if (sel_q.size() == 0) fail("selection with none expected");
      else chk_bits(master_sel, sel_q.pop_front());
    end
    done_d = sel_done;
  end

  task automatic sel_case(input int h0, input int h1, input int h2, input logic [2:0] exp);
    int n;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    half <= '{h0, h1, h2};
    repeat (20) @(posedge ref_clk);
    chk_bits(master_sel, 3'h1);
    chk_bits({1'b0, sel_done, out_valid}, 3'h0);
    sel_q.push_back(exp);
    reset_n <= 1'b1;
    for (n = 0; n < 400 && sel_q.size() != 0; n++) @(posedge ref_clk);
    if (sel_q.size() != 0) fail("no selection made");
  endtask : sel_case

  task automatic frame_case(input logic ord);
    int c;
    int n;
    dri_pkg::dri_word_t e;
    tower_order <= ord;
    for (c = 0; c < 16; c++) begin
      @(posedge ref_clk);
      P.words[c] = lfsr;
    end
    for (c = 0; c < 16; c++) begin
      n = ord ? {c[2:0], c[3]} : c;
      e.chip = n[3:0];
      e.data = P.words[n];
      word_q.push_back(e);
    end
    P.frame();
    for (n = 0; n < 2000 && word_q.size() != 0; n++) @(posedge ref_clk);
    if (word_q.size() != 0) fail("words missing");
    repeat (8) @(posedge ref_clk);
    chk_bits({2'b00, out_valid}, 3'h0);
  endtask : frame_case

  initial begin
    reset_n     = 1'b0;
    tower_order = 1'b0;
    out_ready   = 1'b0;
    cand_clk    = 3'h0;
    done_d      = 1'b0;
    lfsr        = 32'h065F9D11;
    half        = '{0, 0, 0};
    ccnt        = '{0, 0, 0};
    bad_count   = 0;
    cmp_count   = 0;
    sel_case(4, 4, 4, 3'h1);
    sel_case(0, 4, 4, 3'h2);
    sel_case(2, 4, 8, 3'h1);
    frame_case(1'b0);
    frame_case(1'b1);
    final_report();
  end

  // the tests need roughly 2000 cycles
  initial begin
    #200000;
    fail("timeout");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
